// ### common/nvm_mem_if.sv
// port group between the serial engine and the byte array
`timescale 1ns/1ps
`default_nettype none
interface nvm_mem_if (
   input wire logic clk
);
   logic we;
   nvm_pkg::nvm_addr_t addr;
   nvm_pkg::nvm_byte_t wdata;
   nvm_pkg::nvm_byte_t rdata;

   modport ctl (input clk, input rdata, output we, output addr, output wdata);
   modport mem (input clk, input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ### common/nvm_pkg.sv
// types shared by the nonvolatile memory slave and its array
`default_nettype none
package nvm_pkg;
`include "nvm_regs.svh"

   typedef logic [`NVM_ADDR_W-1:0] nvm_addr_t;
   typedef logic [7:0] nvm_byte_t;

   // protocol phases of one addressed frame
   typedef enum logic [2:0] {
      NVM_ST_SADR,
      NVM_ST_MADR_HI,
      NVM_ST_MADR_LO,
      NVM_ST_WDATA,
      NVM_ST_RDATA,
      NVM_ST_IGNORE
   } nvm_state_t;

endpackage
`default_nettype wire

// ### common/nvm_regs.svh
// constants for the two-wire nonvolatile memory slave
// Functional notes
// RL1 - array of 8192 bytes, 13-bit address from two bytes, top 3 bits ignored
// RL2 - answer only when select bits equal the device select pins
// RL3 - sample data on rising clock edge, change output after falling edge
// RL4 - write protect high blocks every write, low allows all writes
// RL5 - data line is open drain: pull low or release, never drive high
// RL6 - master makes the serial clock; this device never drives it
// RL7 - stop is data rising while clock is high
// RL8 - stop during an operation aborts it and returns to idle
// RL9 - start is data falling while clock is high
// RL10 - start anywhere aborts the operation and expects a new slave address
// RL11 - master should open each command with start and close with stop
// RL12 - transmitter keeps data stable while clock high, except start and stop
// RL13 - after eighth bit transmitter releases data, receiver pulls low to acknowledge
// RL14 - released line in acknowledge clock is a no-acknowledge ending the operation
// RL15 - read keeps streaming bytes while master acknowledges and clocks
// RL16 - master leaves the last wanted read byte unacknowledged
// RL17 - first byte after start is the slave address
// RL18 - each data byte is written at once, no busy period
// RL19 - slave address: type code bits 7-4, select bits 3-1, bit 0 read
// RL20 - address increments before each acknowledge and wraps 1FFF to 0000
// RL21 - protected writes get no acknowledge and leave the address unchanged
// RL22 - every byte is sent most significant bit first
// RL23 - unmatched slave address: no acknowledge, ignore bus until next start
`ifndef NVM_REGS_SVH
`define NVM_REGS_SVH

// ******************************************************
// array geometry
// ******************************************************
`define NVM_ADDR_W 13
`define NVM_DEPTH 8192
`define NVM_HI_W 5
`define NVM_ADDR_MAX 13'h1FFF
`define NVM_ADDR_RST 13'h0000

// ******************************************************
// slave address field positions
// ******************************************************
`define NVM_SA_TYPE_MSB 7
`define NVM_SA_TYPE_LSB 4
`define NVM_SA_SEL_MSB 3
`define NVM_SA_SEL_LSB 1
`define NVM_SA_RW 0

// ******************************************************
// bit slot counts within one nine-clock byte
// ******************************************************
`define NVM_BIT_LAST 4'h7
`define NVM_BIT_ACK 4'h8
`define NVM_BIT_FIRST 4'h0

`endif

// ### sim/nvm_bm.sv
// two-wire bus master model that makes the serial clock and drives the data line
`timescale 1ns/1ps
`default_nettype none
module nvm_bm #(
   parameter int QTR = 20
) (
   input wire logic clk,
   input wire logic sda,
   output logic scl,
   output logic pull_low
);
   // ******************************************************
   // bus conditions and clock slots
   // ******************************************************

   // idle bus: clock parked high, data left to the pull-up
   initial begin
      scl = 1'h1;
      pull_low = 1'h0;
   end

   // quarter of a bus period, counted in system clocks so stimulus stays off the sampling edge
   task automatic wait_q();
      repeat (QTR) @(negedge clk);
   endtask

   // one clock slot; data set while the clock is low and held through the high phase
   task automatic clk_bit(input logic drive_low, output logic seen);
      pull_low = drive_low;
      wait_q();
      scl = 1'h1;
      wait_q();
      seen = sda;
      wait_q();
      scl = 1'h0;
      wait_q();
   endtask

   // data falls while the clock is high; also serves as a repeated start
   task automatic start_cond();
      scl = 1'h0;
      pull_low = 1'h0;
      wait_q();
      scl = 1'h1;
      wait_q();
      pull_low = 1'h1;
      wait_q();
      scl = 1'h0;
      wait_q();
   endtask

   // data rises while the clock is high; the clock then stays parked high
   task automatic stop_cond();
      scl = 1'h0;
      pull_low = 1'h1;
      wait_q();
      scl = 1'h1;
      wait_q();
      pull_low = 1'h0;
      wait_q();
   endtask

   // msb first, then the ack slot with the line released for the receiver
   task automatic send_byte(input logic [7:0] b, output logic acked);
      logic seen;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(!b[i], seen);
      end
      clk_bit(1'h0, seen);
      acked = !seen;
   endtask

   // the last wanted byte goes unacknowledged so the device lets go of the line
   task automatic recv_byte(input logic ack, output logic [7:0] b);
      logic seen;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(1'h0, seen);
         b[i] = seen;
      end
      clk_bit(ack, seen);
   endtask
endmodule
`default_nettype wire

// ### sim/nvm_i2c_slave_tb.sv
// self-checking bench for the two-wire nonvolatile memory slave
`timescale 1ns/1ps
`default_nettype none
module nvm_i2c_slave_tb;
   localparam logic [3:0] TYPE_C = 4'h6; // arbitrary type code
   logic clock, resetn, scl, sda, sda_o, sda_oe, wp, m_pull, ack;
   logic [2:0] sel;
   logic [7:0] rb;
   logic [12:0] a;
   logic [7:0] mem_m [0:8191];
   int err_count = 0;
   int checks_done = 0;
   int cycles = 0;
   int addr_m;

   // ******************************************************
   // wiring, clock and watchdog
   // ******************************************************

   // open drain wire with pull-up: any party pulling wins
   assign sda = (sda_oe ? sda_o : 1'h1) & !m_pull;

   nvm_i2c_slave #(.DEV_TYPE(TYPE_C)) u_nvm_i2c_slave (.CLOCK(clock), .RESETN(resetn),
      .SCL(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .WP(wp),
      .DEVICE_SELECT_PINS(sel));
   nvm_bm u_nvm_bm (.clk(clock), .sda(sda), .scl(scl), .pull_low(m_pull));

   // system clock, 5 ns period
   initial begin
      clock = 1'h0;
      forever #2.5 clock = ~clock;
   end

   // a hung bus would stall forever; cut it short
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         err_count++;
         $display("[ERR] run length expected below 90000 seen %0d", cycles);
         end_of_test();
      end
   end

   // the device may only start pulling after the clock falls, and never drives high
   always @(posedge sda_oe) begin
      cmp_ack("pull level", 1'h0, sda_o);
      if (scl === 1'h1) cmp_ack("pull on high clock", 1'h0, 1'h1);
   end

   // ******************************************************
   // compare and frame tasks
   // ******************************************************
   task automatic cmp_ack(input string what, input logic exp, input logic got);
      checks_done++;
      if ((got !== exp) || $isunknown(got)) begin
         err_count++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      // an unknown byte means an unwritten cell was read: never a pass
      if ((got !== exp) || $isunknown(got)) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [7:0] slave_byte(input logic rd);
      return {TYPE_C, sel, rd};
   endfunction

   // addressing phase of a write; the ignored top bits are random
   task automatic set_addr(input logic [12:0] ad);
      u_nvm_bm.start_cond();
      u_nvm_bm.send_byte(slave_byte(1'h0), ack);
      cmp_ack("slave ack", 1'h1, ack);
      u_nvm_bm.send_byte({3'($urandom), ad[12:8]}, ack);
      cmp_ack("addr hi ack", 1'h1, ack);
      u_nvm_bm.send_byte(ad[7:0], ack);
      cmp_ack("addr lo ack", 1'h1, ack);
      addr_m = ad;
   endtask

   // random data bytes into the open write frame, then stop
   task automatic put_bytes(input int n);
      logic [7:0] d;
      for (int i = 0; i < n; i++) begin
         d = 8'($urandom);
         u_nvm_bm.send_byte(d, ack);
         cmp_ack("data ack", 1'h1, ack);
         mem_m[addr_m] = d;
         addr_m = (addr_m + 1) % 8192;
      end
      u_nvm_bm.stop_cond();
   endtask

   // read frame from the current address; the start may abort whatever is open
   task automatic get_bytes(input int n);
      u_nvm_bm.start_cond();
      u_nvm_bm.send_byte(slave_byte(1'h1), ack);
      cmp_ack("read slave ack", 1'h1, ack);
      for (int i = 0; i < n; i++) begin
         u_nvm_bm.recv_byte(i < n - 1, rb);
         cmp_byte("read data", mem_m[addr_m], rb);
         addr_m = (addr_m + 1) % 8192;
      end
      u_nvm_bm.stop_cond();
   endtask

   task automatic end_of_test();
      if (err_count == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end
      else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ******************************************************
   // main sequence
   // ******************************************************
   initial begin
      resetn = 1'h0;
      wp = 1'h0;
      void'($urandom(32'ha409_f315));
      sel = 3'($urandom);
      repeat (5) @(negedge clock);
      resetn = 1'h1;
      repeat (3) @(negedge clock);
      // burst write, selective read back, then a current address read
      a = 13'($urandom);
      set_addr(a);
      put_bytes(5);
      set_addr(a);
      get_bytes(4);
      get_bytes(1);
      // both directions across the top of the array
      set_addr(13'h1ffe);
      put_bytes(3);
      set_addr(13'h1ffe);
      get_bytes(3);
      // every select value, with the right and a wrong type code
      for (int k = 0; k < 16; k++) begin
         u_nvm_bm.start_cond();
         u_nvm_bm.send_byte({k[0] ? TYPE_C : ~TYPE_C, k[3:1], 1'h0}, ack);
         cmp_ack("select match", k[0] && (k[3:1] == sel), ack);
         u_nvm_bm.send_byte(8'h00, ack);
         cmp_ack("byte after select", k[0] && (k[3:1] == sel), ack);
         u_nvm_bm.stop_cond();
      end
      // protected write: no ack, old data kept, latch not stepped
      a = 13'($urandom);
      set_addr(a);
      put_bytes(1);
      wp = 1'h1;
      set_addr(a);
      u_nvm_bm.send_byte(~mem_m[a], ack);
      cmp_ack("protected ack", 1'h0, ack);
      u_nvm_bm.stop_cond();
      wp = 1'h0;
      get_bytes(1);
      // partial byte cut short by a start, then by a stop, writes nothing
      set_addr(a);
      repeat (4) u_nvm_bm.clk_bit(1'h1, ack);
      get_bytes(1);
      set_addr(a);
      repeat (5) u_nvm_bm.clk_bit(1'h1, ack);
      u_nvm_bm.stop_cond();
      get_bytes(1);
      // after a no-ack the device stays off the line
      set_addr(a);
      u_nvm_bm.start_cond();
      u_nvm_bm.send_byte(slave_byte(1'h1), ack);
      u_nvm_bm.recv_byte(1'h0, rb);
      cmp_byte("last read", mem_m[a], rb);
      u_nvm_bm.recv_byte(1'h0, rb);
      cmp_byte("silent after no ack", 8'hff, rb);
      u_nvm_bm.stop_cond();
      // a second reset clears the latch but not the array
      resetn = 1'h0;
      repeat (5) @(negedge clock);
      resetn = 1'h1;
      repeat (3) @(negedge clock);
      addr_m = 0;
      get_bytes(1);
      end_of_test();
   end
endmodule
`default_nettype wire

// ### verilog/nvm_i2c_slave.sv
// two-wire serial slave front end of the 8K x 8 nonvolatile memory
`timescale 1ns/1ps
`default_nettype none
`include "nvm_regs.svh"
module nvm_i2c_slave #(
   // device type code: value is arbitrary, set per product
   parameter logic [3:0] DEV_TYPE = 4'h5
) (
   input wire logic CLOCK,
   input wire logic RESETN,
   input wire logic SCL,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE,
   input wire logic WP,
   input wire logic [2:0] DEVICE_SELECT_PINS
);

   // ******************************************************
   // system clock side: start and stop watch
   // ******************************************************

   logic scl_m_q;
   logic scl_s_q;
   logic scl_p_q;
   logic sda_m_q;
   logic sda_s_q;
   logic sda_p_q;
   logic start_det;
   logic stop_det;
   logic abort_q;
   logic go_q;
   logic link_rst_n;

   // two-flop synchronisers, idle bus reads high
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         scl_m_q <= 1'b1;
         scl_s_q <= 1'b1;
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
      end else begin
         scl_m_q <= SCL;
         scl_s_q <= scl_m_q;
         sda_m_q <= SDA_I;
         sda_s_q <= sda_m_q;
      end
   end

   // one more stage so edges are taken from settled samples only
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_p_q <= scl_s_q;
         sda_p_q <= sda_s_q;
      end
   end

   // data edges while the clock stays high are frame marks
   assign start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q; // RL9
   assign stop_det = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q; // RL7

   // abort holds the clock-side engine in reset; a start arms release,
   // which happens only once the clock is seen low, so the reset never
   // lifts near an edge of the serial clock
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         abort_q <= 1'b1;
         go_q <= 1'b0;
      end else if (start_det) begin
         abort_q <= 1'b1; // RL10
         go_q <= 1'b1;
      end else if (stop_det) begin
         abort_q <= 1'b1; // RL8
         go_q <= 1'b0;
      end else if (go_q && !scl_s_q) begin
         abort_q <= 1'b0;
         go_q <= 1'b0;
      end
   end

   // single flop output, so the link reset cannot glitch
   assign link_rst_n = ~abort_q;
   chk_start_abort : assert property (
      @(posedge CLOCK) disable iff (!RESETN)
      start_det |=> abort_q && go_q) // RL10
      else $error("start did not abort and arm the engine");
   chk_stop_idle : assert property (
      @(posedge CLOCK) disable iff (!RESETN)
      stop_det |=> abort_q && !go_q) // RL8
      else $error("stop did not return the engine to idle");

   // ******************************************************
   // serial clock side: straps and bit slots
   // ******************************************************

   logic wp_m_q;
   logic wp_s_q;
   logic [2:0] sel_m_q;
   logic [2:0] sel_s_q;
   logic [3:0] cnt_q;
   nvm_pkg::nvm_byte_t rx_sh_q;
   nvm_pkg::nvm_byte_t rx_byte;
   logic byte_done;
   logic ack_clk;
   logic sel_hit;
   logic wr_go;

   // strap pins pass two flops; protected until proven otherwise
   always_ff @(posedge SCL or negedge link_rst_n) begin
      if (!link_rst_n) begin
         wp_m_q <= 1'b1;
         wp_s_q <= 1'b1;
         sel_m_q <= 3'h0;
         sel_s_q <= 3'h0;
      end else begin
         wp_m_q <= WP;
         wp_s_q <= wp_m_q;
         sel_m_q <= DEVICE_SELECT_PINS;
         sel_s_q <= sel_m_q;
      end
   end

   // nine clocks per byte: eight bits then the acknowledge slot
   always_ff @(posedge SCL or negedge link_rst_n) begin
      if (!link_rst_n) begin
         cnt_q <= `NVM_BIT_FIRST;
      end else if (cnt_q == `NVM_BIT_ACK) begin
         cnt_q <= `NVM_BIT_FIRST; // RL13
      end else begin
         cnt_q <= cnt_q + 4'h1;
      end
   end

   // data line is timed by the serial clock itself, so it is sampled
   // on that clock's rising edge without a synchroniser
   always_ff @(posedge SCL or negedge link_rst_n) begin
      if (!link_rst_n) begin
         rx_sh_q <= 8'h00;
      end else if (cnt_q != `NVM_BIT_ACK) begin
         rx_sh_q <= {rx_sh_q[6:0], SDA_I}; // RL3 RL22
      end
   end

   // whole byte is visible on the edge of its eighth bit
   assign rx_byte = {rx_sh_q[6:0], SDA_I};
   assign byte_done = (cnt_q == `NVM_BIT_LAST);
   assign ack_clk = (cnt_q == `NVM_BIT_ACK);

   // slave address compare: type code and the three select pins
   assign sel_hit = (rx_byte[`NVM_SA_TYPE_MSB:`NVM_SA_TYPE_LSB] == DEV_TYPE)
      && (rx_byte[`NVM_SA_SEL_MSB:`NVM_SA_SEL_LSB] == sel_s_q); // RL2 RL19

   // ******************************************************
   // serial clock side: protocol phases
   // ******************************************************

   nvm_pkg::nvm_state_t state_q;
   logic ack_ok_q;
   logic rd_q;
   logic [`NVM_HI_W-1:0] hi_q;
   nvm_pkg::nvm_addr_t addr_q;

   // a write goes only in the data phase with protection off
   assign wr_go = byte_done && (state_q == nvm_pkg::NVM_ST_WDATA) && !wp_s_q; // RL4

   // phase moves on the acknowledge edge; every frame opens on the
   // slave address because the link reset parks the phase there
   always_ff @(posedge SCL or negedge link_rst_n) begin
      if (!link_rst_n) begin
         state_q <= nvm_pkg::NVM_ST_SADR; // RL17
      end else if (ack_clk) begin
         case (state_q)
            nvm_pkg::NVM_ST_SADR: begin
               if (!ack_ok_q) begin
                  state_q <= nvm_pkg::NVM_ST_IGNORE; // RL23
               end else if (rd_q) begin
                  state_q <= nvm_pkg::NVM_ST_RDATA;
               end else begin
                  state_q <= nvm_pkg::NVM_ST_MADR_HI;
               end
            end
            nvm_pkg::NVM_ST_MADR_HI: begin
               state_q <= nvm_pkg::NVM_ST_MADR_LO;
            end
            nvm_pkg::NVM_ST_MADR_LO: begin
               state_q <= nvm_pkg::NVM_ST_WDATA;
            end
            nvm_pkg::NVM_ST_WDATA: begin
               // a refused byte ends the write; a start is needed again
               if (!ack_ok_q) begin
                  state_q <= nvm_pkg::NVM_ST_IGNORE; // RL21
               end
            end
            nvm_pkg::NVM_ST_RDATA: begin
               // released line from the master ends the read
               if (SDA_I) begin
                  state_q <= nvm_pkg::NVM_ST_IGNORE; // RL14
               end else begin
                  state_q <= nvm_pkg::NVM_ST_RDATA; // RL15
               end
            end
            default: begin // ignored frames wait for the next start
               state_q <= nvm_pkg::NVM_ST_IGNORE;
            end
         endcase
      end
   end

   // decide the answer for the coming acknowledge slot
   always_ff @(posedge SCL or negedge link_rst_n) begin
      if (!link_rst_n) begin
         ack_ok_q <= 1'b0;
      end else if (byte_done) begin
         case (state_q)
            nvm_pkg::NVM_ST_SADR: ack_ok_q <= sel_hit; // RL2 RL23
            nvm_pkg::NVM_ST_MADR_HI: ack_ok_q <= 1'b1;
            nvm_pkg::NVM_ST_MADR_LO: ack_ok_q <= 1'b1;
            nvm_pkg::NVM_ST_WDATA: ack_ok_q <= !wp_s_q; // RL21
            default: ack_ok_q <= 1'b0;
         endcase
      end
   end

   // direction bit of the slave address
   always_ff @(posedge SCL or negedge link_rst_n) begin
      if (!link_rst_n) begin
         rd_q <= 1'b0;
      end else if (byte_done && (state_q == nvm_pkg::NVM_ST_SADR)) begin
         rd_q <= rx_byte[`NVM_SA_RW]; // RL19
      end
   end

   // current address survives aborts and only a board reset clears it;
   // the top three bits of the high address byte are dropped
   always_ff @(posedge SCL or negedge RESETN) begin
      if (!RESETN) begin
         hi_q <= 5'h00;
      end else if (link_rst_n && byte_done && (state_q == nvm_pkg::NVM_ST_MADR_HI)) begin
         hi_q <= rx_byte[`NVM_HI_W-1:0]; // RL1
      end
   end

   // address latch: loaded by the second address byte, stepped before
   // each acknowledge of a read byte or an accepted write byte
   always_ff @(posedge SCL or negedge RESETN) begin
      if (!RESETN) begin
         addr_q <= `NVM_ADDR_RST;
      end else if (link_rst_n && byte_done) begin
         if (state_q == nvm_pkg::NVM_ST_MADR_LO) begin
            addr_q <= {hi_q, rx_byte}; // RL1
         end else if (wr_go || (state_q == nvm_pkg::NVM_ST_RDATA)) begin
            if (addr_q == `NVM_ADDR_MAX) begin
               addr_q <= `NVM_ADDR_RST; // RL20
            end else begin
               addr_q <= addr_q + 13'h0001; // RL20
            end
         end
      end
   end

   // ******************************************************
   // byte array
   // ******************************************************

   nvm_mem_if mif (
      .clk(SCL)
   );

   // write data is the byte completed on this very edge
   assign mif.we = wr_go && link_rst_n; // RL18
   assign mif.addr = addr_q;
   assign mif.wdata = rx_byte;

   nvm_mem u_mem (
      .m(mif.mem)
   );

   // ******************************************************
   // serial clock side: data line drive
   // ******************************************************

   logic pull_q;
   nvm_pkg::nvm_byte_t tx_sh_q;

   // changes follow the falling edge; a reset releases the line at once,
   // which is how a start or stop frees the bus mid byte
   always_ff @(negedge SCL or negedge link_rst_n) begin
      if (!link_rst_n) begin
         pull_q <= 1'b0;
         tx_sh_q <= 8'hFF;
      end else if (cnt_q == `NVM_BIT_ACK) begin
         // receiver acknowledges; as transmitter we release the slot
         pull_q <= ack_ok_q && (state_q != nvm_pkg::NVM_ST_RDATA); // RL13
      end else if (state_q == nvm_pkg::NVM_ST_RDATA) begin
         if (cnt_q == `NVM_BIT_FIRST) begin
            pull_q <= ~mif.rdata[7]; // RL3 RL12 RL22
            tx_sh_q <= {mif.rdata[6:0], 1'b1};
         end else begin
            pull_q <= ~tx_sh_q[7]; // RL3 RL12 RL22
            tx_sh_q <= {tx_sh_q[6:0], 1'b1};
         end
      end else begin
         pull_q <= 1'b0;
      end
   end

   // open drain: the level driven is always low, only the enable moves
   assign SDA_O = 1'b0; // RL5
   assign SDA_OE = pull_q; // RL5

   // ******************************************************
   // checks on the serial clock side
   // ******************************************************

   sequence s_read_acked;
      (state_q == nvm_pkg::NVM_ST_RDATA) && ack_clk && !SDA_I;
   endsequence
   sequence s_next_byte_out;
      (state_q == nvm_pkg::NVM_ST_RDATA) && (cnt_q == `NVM_BIT_FIRST);
   endsequence
   chk_read_stream : assert property (
      @(posedge SCL) disable iff (!link_rst_n)
      s_read_acked |=> s_next_byte_out) // RL15
      else $error("acknowledged read did not continue");
   chk_read_nack : assert property (
      @(posedge SCL) disable iff (!link_rst_n)
      (state_q == nvm_pkg::NVM_ST_RDATA) && ack_clk && SDA_I
      |=> (state_q == nvm_pkg::NVM_ST_IGNORE)) // RL14
      else $error("no-acknowledge did not end the read");
   chk_addr_wrap : assert property (
      @(posedge SCL) disable iff (!link_rst_n)
      (state_q == nvm_pkg::NVM_ST_RDATA) && byte_done && (addr_q == 13'h1FFF)
      |=> (addr_q == 13'h0000)) // RL20
      else $error("address did not wrap to zero");
   chk_wp_block : assert property (
      @(posedge SCL) disable iff (!link_rst_n)
      (state_q == nvm_pkg::NVM_ST_WDATA) && byte_done && wp_s_q
      |-> !mif.we ##1 ($stable(addr_q) && !ack_ok_q)) // RL4 RL21
      else $error("protected write was not refused");
   chk_write_now : assert property (
      @(posedge SCL) disable iff (!link_rst_n)
      (state_q == nvm_pkg::NVM_ST_WDATA) && byte_done && !wp_s_q
      |-> mif.we ##1 (u_mem.mem_q[$past(addr_q)] == $past(rx_byte))) // RL18
      else $error("accepted byte was not written at once");
   chk_bad_slave : assert property (
      @(posedge SCL) disable iff (!link_rst_n)
      (state_q == nvm_pkg::NVM_ST_SADR) && byte_done
      && (rx_byte[3:1] != sel_s_q)
      |=> !ack_ok_q ##1 (state_q == nvm_pkg::NVM_ST_IGNORE)) // RL2 RL23
      else $error("foreign slave address was acknowledged");
   chk_ignore_quiet : assert property (
      @(posedge SCL) disable iff (!link_rst_n)
      (state_q == nvm_pkg::NVM_ST_IGNORE)
      |-> !pull_q ##1 (state_q == nvm_pkg::NVM_ST_IGNORE)) // RL23
      else $error("ignored frame touched the bus");
   chk_ack_driven : assert property (
      @(posedge SCL) disable iff (!link_rst_n)
      ack_clk && ack_ok_q && (state_q != nvm_pkg::NVM_ST_RDATA)
      |-> pull_q ##1 (cnt_q == `NVM_BIT_FIRST)) // RL13
      else $error("acknowledge slot not pulled low");
   chk_tx_release : assert property (
      @(posedge SCL) disable iff (!link_rst_n)
      (state_q == nvm_pkg::NVM_ST_RDATA) && ack_clk |-> !pull_q) // RL13
      else $error("transmitter held the line in the acknowledge slot");

endmodule
`default_nettype wire

// ### verilog/nvm_mem.sv
// 8K x 8 byte array with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "nvm_regs.svh"
module nvm_mem (
   nvm_mem_if.mem m
);
   // array keeps its contents across resets, like the cells it stands for
   nvm_pkg::nvm_byte_t mem_q [0:`NVM_DEPTH-1];
   nvm_pkg::nvm_byte_t rdata_q;

   // write lands on the same edge that samples the eighth bit
   always_ff @(posedge m.clk) begin
      if (m.we) begin
         mem_q[m.addr] <= m.wdata; // RL18
      end
   end

   // read every edge; the engine picks the word up on the ack clock
   always_ff @(posedge m.clk) begin
      rdata_q <= mem_q[m.addr];
   end

   assign m.rdata = rdata_q;
endmodule
`default_nettype wire
